// *** bench/pin_partner.sv ***
// Board-side model driving the shift register pins: both stage clocks, mode, serial and parallel data.
// Assumes a free-running i_mclk; pin changes follow its rising edge, except the first mode edge hold, which follows a falling edge.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Pin driver
// ----------------------------------------------------------------------
module pin_partner (
  input wire logic i_mclk,
  input wire logic [3:0] i_stage,
  output logic o_clk1,
  output logic o_clk2,
  output logic o_mode,
  output logic o_serial,
  output logic [3:0] o_par
);
  logic left_reg;
  logic [3:0] par_reg;

  // Left shift needs feedback wiring: each stage output feeds the input of the stage before it.
  assign o_par = left_reg ? {i_stage[2:0], o_serial} : par_reg;

  // All pins start low so no clock fall is seen after reset.
  initial begin
    {o_clk1, o_clk2, o_mode, o_serial, left_reg, par_reg} = '0;
  end

  // One step: data and mode settle before the clocks are driven, then one clean pulse.
  task automatic pulse(input logic m, input logic c1, input logic c2, input logic s, input logic [3:0] p,
                       input logic l);
    o_mode <= m;
    o_serial <= s;
    par_reg <= p;
    left_reg <= l;
    repeat (3) @(posedge i_mclk);
    o_clk1 <= c1;
    o_clk2 <= c2;
    repeat (3) @(posedge i_mclk);
    o_clk1 <= 1'b0;
    o_clk2 <= 1'b0;
    repeat (6) @(posedge i_mclk);
  endtask

  // Steady levels held for a few cycles; used for mode edges with clocks parked.
  task automatic hold(input logic c1, input logic c2, input logic m);
    o_clk1 <= c1;
    o_clk2 <= c2;
    o_mode <= m;
    repeat (5) @(posedge i_mclk);
  endtask
endmodule

`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the shift register core and its snapshot stream.
// Assumes pin_partner drives the pins; expectations come from next_stage below.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end

module tb_top;
  import shift4_pkg::*;
  logic i_mclk, i_rst, i_ce, i_snap_ready, snap_valid, room, lost, exp_lost, m, c1, c2, s, l;
  wire logic clk1, clk2, mode, serial;
  wire logic [3:0] par, stage;
  logic [3:0] snap_data, exp_st, p, sel, exp_snap;
  logic [3:0] q[$];
  int n_mismatch, compares;

  // ----------------------------------------------------------------------
  // Clock, design and partner
  // ----------------------------------------------------------------------
  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end

  shift4_core i_shift4_core (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_clk1_pin(clk1),
    .i_clk2_pin(clk2), .i_mode_pin(mode), .i_serial_pin(serial), .i_par_pin(par),
    .o_stage_first_out(stage[3]), .o_stage_second_out(stage[2]), .o_stage_third_out(stage[1]),
    .o_stage_last_out(stage[0]), .o_snap_valid(snap_valid), .i_snap_ready(i_snap_ready),
    .o_snap_data(snap_data), .o_snap_room(room), .o_snap_lost(lost));

  pin_partner i_pin_partner (.i_mclk(i_mclk), .i_stage(stage), .o_clk1(clk1), .o_clk2(clk2),
    .o_mode(mode), .o_serial(serial), .o_par(par));

  // ----------------------------------------------------------------------
  // Reference and reporting
  // ----------------------------------------------------------------------
  // Only the clock that the mode selects moves the stages; a load takes fp, or with feedback wiring puts the serial pin into the last stage.
  function automatic logic [3:0] next_stage(logic [3:0] old, logic fm, logic f1, logic f2, logic fs,
                                            logic [3:0] fp, logic fl);
    if (fm && f2) return fl ? {old[2:0], fs} : fp;
    if (!fm && f1) return {fs, old[3:1]};
    return old;
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the few hundred cycles the tests need.
  initial begin
    #(40 * 4000);
    n_mismatch++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    {i_rst, i_ce, i_snap_ready, exp_lost, exp_st} = {3'b110, 5'h0_0};
    void'($urandom(72));
    repeat (6) @(posedge i_mclk);
    i_rst <= 1'b0;
    // Steps with the FIFO stalled: the first six always step, so the FIFO overflows.
    for (int i = 0; i < 12; i++) begin
      sel = 4'($urandom);
      m = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : sel[2];
      c2 = (i < 6) ? (m | sel[1]) : sel[1];
      c1 = (i < 6) ? (~m | sel[0]) : sel[0];
      if (i == 1) {c1, c2} = 2'b11;
      s = sel[3];
      p = (i == 0) ? 4'ha : 4'($urandom);
      l = (i == 0) ? 1'b0 : m & 1'($urandom);
      if ((m && c2) || (!m && c1)) begin
        if (q.size() < SNAP_DEPTH) q.push_back(next_stage(exp_st, m, c1, c2, s, p, l));
        else exp_lost = 1'b1;
      end
      exp_st = next_stage(exp_st, m, c1, c2, s, p, l);
      i_pin_partner.pulse(m, c1, c2, s, p, l);
      `CHK(stage, exp_st)
    end
    `CHK(lost, exp_lost)
    `CHK(room, 1'b0)
    $display("test steps done");
    // Drain back to back and compare every snapshot in step order.
    @(posedge i_mclk);
    i_snap_ready <= 1'b1;
    while (q.size() > 0) begin
      @(negedge i_mclk);
      // The macro names its expected value twice, so the head is popped once beforehand.
      exp_snap = q.pop_front();
      `CHK(snap_valid, 1'b1)
      `CHK(snap_data, exp_snap)
      @(posedge i_mclk);
    end
    i_snap_ready <= 1'b0;
    @(negedge i_mclk);
    `CHK(snap_valid, 1'b0)
    `CHK(room, 1'b1)
    $display("test drain done");
    // Mode rises with the first clock parked high, then that clock falls while unselected.
    i_pin_partner.hold(1'b1, 1'b0, 1'b0);
    i_pin_partner.hold(1'b1, 1'b0, 1'b1);
    i_pin_partner.hold(1'b0, 1'b0, 1'b1);
    i_pin_partner.hold(1'b0, 1'b0, 1'b0);
    `CHK(stage, exp_st)
    `CHK(snap_valid, 1'b0)
    $display("test mode edge done");
    // A load pulse while the clock enable is low must be lost entirely.
    i_ce <= 1'b0;
    i_pin_partner.pulse(1'b1, 1'b0, 1'b1, 1'b0, ~exp_st, 1'b0);
    i_ce <= 1'b1;
    repeat (4) @(posedge i_mclk);
    `CHK(stage, exp_st)
    $display("test enable done");
    // Reset in mid-run clears stages, stream and the sticky flag.
    // The first clock stays parked high across the release, so a false fall would show here.
    i_pin_partner.hold(1'b0, 1'b0, 1'b0);
    i_pin_partner.hold(1'b1, 1'b0, 1'b0);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(negedge i_mclk);
    `CHK({stage, snap_valid, room, lost}, {STAGE_RST, 3'h2})
    repeat (4) @(negedge i_mclk);
    `CHK({stage, snap_valid}, {STAGE_RST, 1'b0})
    // The first real fall after the release must still shift.
    @(posedge i_mclk);
    exp_st = next_stage(STAGE_RST, 1'b0, 1'b1, 1'b0, 1'b1, 4'h0, 1'b0);
    i_pin_partner.pulse(1'b0, 1'b1, 1'b0, 1'b1, 4'h0, 1'b0);
    @(negedge i_mclk);
    `CHK({stage, snap_valid, snap_data}, {exp_st, 1'b1, exp_st})
    $display("test reset done");
    tally_and_finish();
  end
endmodule

`default_nettype wire

// *** design/shift4_core.sv ***
// Four-stage bidirectional shift register with parallel load, plus a snapshot FIFO.
// Assumes the pins (both stage clocks, mode, serial and parallel inputs) are
// asynchronous to i_mclk and change no faster than a few system clock periods.
//
// Contract
// - Mode high: second clock falling edge loads all four parallel inputs into stages.
// - During a parallel load the serial input has no effect at all.
// - Mode low: first clock falling edge shifts toward last stage, serial enters first.
// - Second clock acts only with mode high, first only with mode low.
// - Without an active falling clock edge, every stage keeps its level.
// - A rising mode edge with steady clocks leaves the stages untouched.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Snapshot FIFO
// ----------------------------------------------------------------------
module snap_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 4
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic push;
  logic pop;

  // Handshakes are combinational; a full FIFO refuses, an empty one shows nothing.
  assign o_in_ready = (count_reg != CW'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign push = i_ce && i_in_valid && o_in_ready;
  assign pop = i_ce && i_out_ready && o_out_valid;
  assign o_out_data = mem[rd_ptr_reg];

  // Storage is written only on an accepted word, so it needs no reset.
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
      end
    end
  end

  // Occupancy count drives the full and empty flags.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      count_reg <= '0;
    end else if (push && !pop) begin
      count_reg <= count_reg + CW'(1);
    end else if (pop && !push) begin
      count_reg <= count_reg - CW'(1);
    end
  end

  // The count never passes the depth.
  a_fifo_bound: assert property (@(posedge i_mclk) disable iff (i_rst) count_reg <= CW'(DEPTH))
    else $error("snapshot fifo count beyond depth");
endmodule

// ----------------------------------------------------------------------
// Shift register core
// ----------------------------------------------------------------------
module shift4_core
  import shift4_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_clk1_pin,
  input wire logic i_clk2_pin,
  input wire logic i_mode_pin,
  input wire logic i_serial_pin,
  input wire logic [3:0] i_par_pin,
  output logic o_stage_first_out,
  output logic o_stage_second_out,
  output logic o_stage_third_out,
  output logic o_stage_last_out,
  output logic o_snap_valid,
  input wire logic i_snap_ready,
  output logic [3:0] o_snap_data,
  output logic o_snap_room,
  output logic o_snap_lost
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  pin_in_t pin_raw;
  pin_in_t meta_reg;
  pin_in_t sync_reg;
  logic [1:0] clk_prev_reg;
  stage_t stage_reg;
  stage_t stage_next;
  step_t step;
  logic fall1;
  logic fall2;
  logic snap_push;
  logic snap_room;
  logic lost_reg;

  assign pin_raw = '{clk1: i_clk1_pin, clk2: i_clk2_pin, mode: i_mode_pin,
                     serial: i_serial_pin, par: i_par_pin};

  // Two flops on every pin; the first is read only by the second.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else if (i_ce) begin
      meta_reg <= pin_raw;
      sync_reg <= meta_reg;
    end
  end

  // Previous synchronised clock levels, for falling edge detection.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      clk_prev_reg <= SYNC_RST;
    end else if (i_ce) begin
      clk_prev_reg <= {sync_reg.clk2, sync_reg.clk1};
    end
  end

  // ----------------------------------------------------------------------
  // Edge selection
  // ----------------------------------------------------------------------
  // Mode is sampled through the same two flops as the clocks, so a mode change
  // made while both clocks are low can never pair with a stale clock level.
  assign fall1 = clk_prev_reg[0] && !sync_reg.clk1;
  assign fall2 = clk_prev_reg[1] && !sync_reg.clk2;

  // Only the clock that the mode selects can cause a step; a mode edge alone
  // is never an event, so it leaves the stages alone.
  always_comb begin
    step = STEP_NONE;
    if (i_ce) begin
      if (sync_reg.mode && fall2) begin
        step = STEP_LOAD;
      end else if (!sync_reg.mode && fall1) begin
        step = STEP_SHIFT;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Stage register
  // ----------------------------------------------------------------------
  // Load takes all four inputs and never looks at the serial pin; shift moves
  // data toward the last stage. Shift-left needs the outside feedback wiring.
  always_comb begin
    stage_next = stage_reg;
    case (step)
      STEP_LOAD: begin
        stage_next = stage_t'(sync_reg.par);
      end
      STEP_SHIFT: begin
        stage_next = '{first: sync_reg.serial, second: stage_reg.first,
                       third: stage_reg.second, last: stage_reg.third};
      end
      STEP_NONE: begin
        stage_next = stage_reg;
      end
      default: begin
        stage_next = stage_reg;
      end
    endcase
  end

  // One register for both clocks; there is no second storage path.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      stage_reg <= stage_t'(STAGE_RST);
    end else if (i_ce) begin
      stage_reg <= stage_next;
    end
  end

  assign o_stage_first_out = stage_reg.first;
  assign o_stage_second_out = stage_reg.second;
  assign o_stage_third_out = stage_reg.third;
  assign o_stage_last_out = stage_reg.last;

  // ----------------------------------------------------------------------
  // Snapshot stream
  // ----------------------------------------------------------------------
  // Each step pushes the new contents. The pins cannot be stalled, so the
  // register still steps when the FIFO is full; the room output warns the
  // consumer and a sticky flag records the dropped snapshot.
  assign snap_push = (step != STEP_NONE);
  assign o_snap_room = snap_room;

  snap_fifo #(
    .WIDTH(STAGE_W),
    .DEPTH(SNAP_DEPTH)
  ) u_snap_fifo (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_in_valid(snap_push),
    .o_in_ready(snap_room),
    .i_in_data(stage_next),
    .o_out_valid(o_snap_valid),
    .i_out_ready(i_snap_ready),
    .o_out_data(o_snap_data)
  );

  // Lost flag stays set until reset.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      lost_reg <= 1'b0;
    end else if (i_ce && snap_push && !snap_room) begin
      lost_reg <= 1'b1;
    end
  end

  assign o_snap_lost = lost_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  sequence s_load_edge;
    i_ce && sync_reg.mode && fall2;
  endsequence

  sequence s_shift_edge;
    i_ce && !sync_reg.mode && fall1;
  endsequence

  a_load_capture: assert property (s_load_edge |=> stage_reg == stage_t'($past(sync_reg.par)))
    else $error("parallel load did not capture inputs");

  a_load_serial: assert property (s_load_edge |=> stage_reg.first == $past(sync_reg.par[3]))
    else $error("serial input leaked into a parallel load");

  a_shift_right: assert property (s_shift_edge |=>
      stage_reg == {$past(sync_reg.serial), $past(stage_reg[3:1])})
    else $error("shift right produced wrong contents");

  a_wrong_clock: assert property ((i_ce && !fall1 && fall2 && !sync_reg.mode) or
      (i_ce && !fall2 && fall1 && sync_reg.mode) |=> $stable(stage_reg))
    else $error("unselected clock changed the stages");

  a_hold_steady: assert property (!(fall1 || fall2) |=> $stable(stage_reg))
    else $error("stages changed without a clock edge");

  a_mode_rise: assert property ($rose(sync_reg.mode) && !fall1 && !fall2 |=> $stable(stage_reg))
    else $error("mode rise altered the stages");

  a_single_path: assert property ((step != STEP_NONE) |=> o_snap_valid || $past(!snap_room))
    else $error("step not reflected in the snapshot stream");

endmodule

`default_nettype wire

// *** design/shift4_pkg.sv ***
// Shared constants and carrier types for the four-stage bidirectional shift register.
// Assumes a single system clock; all pin inputs are asynchronous to it.
package shift4_pkg;

  // ----------------------------------------------------------------------
  // Widths, depths and reset values
  // ----------------------------------------------------------------------
  localparam int STAGE_W = 4;
  localparam int SNAP_DEPTH = 4;
  localparam logic [3:0] STAGE_RST = 4'h0;
  localparam logic [1:0] SYNC_RST = 2'h0;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  // Stored stage contents, first stage in the top bit.
  typedef struct packed {
    logic first;
    logic second;
    logic third;
    logic last;
  } stage_t;

  // Pin levels after synchronisation.
  typedef struct packed {
    logic clk1;
    logic clk2;
    logic mode;
    logic serial;
    logic [3:0] par;
  } pin_in_t;

  // Kind of stage update taken in one system clock cycle.
  typedef enum logic [1:0] {
    STEP_NONE,
    STEP_LOAD,
    STEP_SHIFT
  } step_t;

endpackage
